// >>> inc/reb_cfg.svh
// Behaviour
// - Rate mismatch is absorbed by adding or dropping idles, only inside gaps.
// - Each interframe gap steers the fill level back toward half full.
// - One storage location holds one decoded character (one byte).
// - Occupancy reaching the overflow or underflow mark raises an error.
// - Transceiver variant: overflow mark 61, underflow mark 8.
// - Transceiver variant: target 32, frame-start occupancy band 33 to 36.
// - Fabric variant: overflow mark 122, underflow mark 6.
// - Fabric variant: target 64, frame-start band 62 to 66.
// - Ten-bit interface in SGMII mode reuses the fabric variant settings.
// - Ten-bit 1000BASE-X variant: overflow mark 30, underflow mark 2.
// - Ten-bit 1000BASE-X variant: target 16, band 14 to 18.
// - Only second-idle pairs are added or dropped; other gap symbols pass.
// - Dropping one second-idle pair removes two bytes.
// - While draining, any number of second-idle pairs may be added.
// - Every second-idle pair in a gap is eligible for removal.
// - A second idle is comma on even slot then data on odd slot.
`ifndef REB_CFG_SVH
`define REB_CFG_SVH

`define REB_K_COMMA 8'hBC
`define REB_D_IDLE2 8'h50
`define REB_K_SOP 8'hFB
`define REB_K_EOP 8'hFD

`define REB_XCVR_DEPTH 64
`define REB_XCVR_HALF 32
`define REB_XCVR_OVF 61
`define REB_XCVR_UDF 8
`define REB_XCVR_LO 33
`define REB_XCVR_HI 36

`define REB_FAB_DEPTH 128
`define REB_FAB_HALF 64
`define REB_FAB_OVF 122
`define REB_FAB_UDF 6
`define REB_FAB_LO 62
`define REB_FAB_HI 66

`define REB_TBI_DEPTH 32
`define REB_TBI_HALF 16
`define REB_TBI_OVF 30
`define REB_TBI_UDF 2
`define REB_TBI_LO 14
`define REB_TBI_HI 18

`define REB_CLK_PERIOD_NS 10
`define REB_RD_PERIOD_NS 160

`endif

// >>> inc/reb_pkg.sv
package reb_pkg;

  typedef struct packed {
    logic k;
    logic [7:0] d;
  } reb_char_t;

  typedef enum logic {
    REB_RD_PASS,
    REB_RD_INS
  } reb_rd_state_t;

endpackage : reb_pkg

// >>> inc/reb_ptr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface reb_ptr_if #(parameter int AW = 6);
  logic [AW:0] src_gray;
  logic [AW:0] dst_gray;
  modport owner (output src_gray, input dst_gray);
  modport sync (input src_gray, output dst_gray);
endinterface : reb_ptr_if
`default_nettype wire

// >>> design/reb_gray_sync.sv
`timescale 1ns/10ps
`default_nettype none
module reb_gray_sync #(
  parameter int AW = 6
) (
  input wire logic sys_clk,
  input wire logic rst,
  reb_ptr_if.sync ptr
);

  logic [AW:0] stage1_ff;
  logic [AW:0] stage2_ff;

  // per-bit pair of flops; gray code keeps a skewed sample one step off
  genvar gi;
  generate
    for (gi = 0; gi <= AW; gi++) begin : g_bit
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          stage1_ff[gi] <= 1'b0;
          stage2_ff[gi] <= 1'b0;
        end else begin
          stage1_ff[gi] <= ptr.src_gray[gi];
          stage2_ff[gi] <= stage1_ff[gi];
        end
      end
    end
  endgenerate

  assign ptr.dst_gray = stage2_ff;

endmodule : reb_gray_sync
`default_nettype wire

// >>> design/reb_elastic_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "reb_cfg.svh"
module reb_elastic_top #(
  parameter int DEPTH = `REB_XCVR_DEPTH,
  parameter int HALF = `REB_XCVR_HALF,
  parameter int OVF_MARK = `REB_XCVR_OVF,
  parameter int UDF_MARK = `REB_XCVR_UDF,
  parameter int CC_LO = `REB_XCVR_LO,
  parameter int CC_HI = `REB_XCVR_HI
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic [7:0] link_data,
  input wire logic link_is_k,
  output logic [7:0] rx_data,
  output logic rx_is_k,
  output logic rx_valid,
  output logic ovf_err,
  output logic udf_err
);

  localparam int AW = $clog2(DEPTH);
  localparam int RD_DIV = `REB_RD_PERIOD_NS / `REB_CLK_PERIOD_NS;
  localparam int DW = (RD_DIV > 1) ? $clog2(RD_DIV) : 1;
  localparam logic [AW:0] DEPTH_L = DEPTH[AW:0];
  localparam logic [AW:0] HALF_L = HALF[AW:0];
  localparam logic [AW:0] OVF_L = OVF_MARK[AW:0];
  localparam logic [AW:0] UDF_L = UDF_MARK[AW:0];
  localparam logic [AW:0] LO_L = CC_LO[AW:0];
  localparam logic [AW:0] HI_L = CC_HI[AW:0];
  localparam logic [DW-1:0] DIV_END = DW'(RD_DIV - 1);
  localparam reb_pkg::reb_char_t COMMA = '{k: 1'b1, d: `REB_K_COMMA};
  localparam reb_pkg::reb_char_t IDLE2 = '{k: 1'b0, d: `REB_D_IDLE2};
  localparam reb_pkg::reb_char_t SOP = '{k: 1'b1, d: `REB_K_SOP};
  localparam reb_pkg::reb_char_t EOP = '{k: 1'b1, d: `REB_K_EOP};

  // refuse geometries the pointer and threshold logic cannot serve
  if ((DEPTH != (1 << AW)) || (DEPTH < 8)) begin : g_bad_depth
    $error("depth must be a power of two, at least 8");
  end
  if (!((UDF_MARK < CC_LO) && (CC_LO <= HALF) && (HALF <= CC_HI)
        && (CC_HI < OVF_MARK) && (OVF_MARK < DEPTH))) begin : g_bad_marks
    $error("marks must satisfy udf < lo <= half <= hi < ovf < depth");
  end
  if (RD_DIV < 1) begin : g_bad_div
    $error("read period shorter than the system clock");
  end

  function automatic logic [AW:0] g2b(input logic [AW:0] g);
    logic [AW:0] b;
    b = '0;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction : g2b

  function automatic logic [AW:0] b2g(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : b2g

  reb_ptr_if #(.AW(AW)) wr_if ();
  reb_ptr_if #(.AW(AW)) rd_if ();

  reb_gray_sync #(.AW(AW)) u_wr_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .ptr(wr_if.sync)
  );

  reb_gray_sync #(.AW(AW)) u_rd_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .ptr(rd_if.sync)
  );

  reb_pkg::reb_char_t mem [DEPTH];

  // ---------------- link-facing write side ----------------
  logic [2:0] lclk_sync_ff;
  reb_pkg::reb_char_t ld_s1_ff;
  reb_pkg::reb_char_t ld_s2_ff;
  reb_pkg::reb_char_t hold_ff;
  logic hold_vld_ff;
  logic wr_in_frame_ff;
  logic [AW:0] wr_bin_ff;
  logic [AW:0] wr_gray_ff;
  logic [AW:0] wr_occ;
  logic wr_edge;
  logic i2_pair;
  logic drop;
  logic wr_en;
  logic ovf_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lclk_sync_ff <= '0;
      ld_s1_ff <= '0;
      ld_s2_ff <= '0;
    end else begin
      lclk_sync_ff <= {lclk_sync_ff[1:0], link_clk};
      ld_s1_ff <= '{k: link_is_k, d: link_data};
      ld_s2_ff <= ld_s1_ff;
    end
  end

  assign wr_edge = lclk_sync_ff[1] & ~lclk_sync_ff[2];
  assign wr_occ = wr_bin_ff - g2b(rd_if.dst_gray);
  // the comma is held back one character so a whole pair can be dropped
  assign i2_pair = hold_vld_ff && (hold_ff == COMMA) && (ld_s2_ff == IDLE2);
  assign drop = wr_edge && i2_pair && !wr_in_frame_ff && (wr_occ > HI_L);
  assign wr_en = wr_edge && hold_vld_ff && !drop && (wr_occ < DEPTH_L);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_ff <= '0;
      hold_vld_ff <= 1'b0;
    end else if (drop) begin
      hold_vld_ff <= 1'b0;
    end else if (wr_edge) begin
      hold_ff <= ld_s2_ff;
      hold_vld_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_in_frame_ff <= 1'b0;
    end else if (wr_edge && (ld_s2_ff == SOP)) begin
      wr_in_frame_ff <= 1'b1;
    end else if (wr_edge && (ld_s2_ff == EOP)) begin
      wr_in_frame_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_bin_ff[AW-1:0]] <= hold_ff;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_bin_ff <= '0;
      wr_gray_ff <= '0;
    end else if (wr_en) begin
      wr_bin_ff <= wr_bin_ff + 1'b1;
      wr_gray_ff <= b2g(wr_bin_ff + 1'b1);
    end
  end

  assign wr_if.src_gray = wr_gray_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ovf_ff <= 1'b0;
    end else begin
      ovf_ff <= wr_edge && (wr_occ >= OVF_L);
    end
  end

  // ---------------- core-facing read side ----------------
  logic [DW-1:0] div_ff;
  logic rd_tick;
  logic rd_run_ff;
  logic [AW:0] rd_bin_ff;
  logic [AW:0] rd_gray_ff;
  logic [AW:0] rd_occ;
  reb_pkg::reb_char_t head;
  reb_pkg::reb_rd_state_t rd_state_ff;
  reb_pkg::reb_rd_state_t nxt_state;
  reb_pkg::reb_char_t nxt_out;
  logic nxt_go;
  logic rd_adv;
  logic ins_ok;
  logic rd_in_frame_ff;
  logic prev_comma_ff;
  logic last_i2_ff;
  reb_pkg::reb_char_t out_ff;
  logic valid_ff;
  logic udf_ff;

  // read slots arrive at the nominal byte rate as one-cycle enables
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_ff <= '0;
    end else if (div_ff == DIV_END) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  assign rd_tick = (div_ff == DIV_END);
  assign rd_occ = g2b(wr_if.dst_gray) - rd_bin_ff;
  assign head = mem[rd_bin_ff[AW-1:0]];

  // reading starts only once the first fill reaches half; underflow at
  // power-up would otherwise be reported before any data arrived
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_run_ff <= 1'b0;
    end else if (rd_occ >= HALF_L) begin
      rd_run_ff <= 1'b1;
    end
  end

  // a new pair goes in only on an even boundary after a complete idle
  assign ins_ok = !rd_in_frame_ff && last_i2_ff && (rd_occ != '0)
                  && (head == COMMA) && (rd_occ < LO_L);

  always_comb begin
    nxt_state = rd_state_ff;
    nxt_out = out_ff;
    nxt_go = 1'b0;
    rd_adv = 1'b0;
    if (rd_tick && rd_run_ff) begin
      case (rd_state_ff)
        reb_pkg::REB_RD_PASS: begin
          if (ins_ok) begin
            nxt_out = COMMA;
            nxt_go = 1'b1;
            nxt_state = reb_pkg::REB_RD_INS;
          end else if (rd_occ != '0) begin
            nxt_out = head;
            nxt_go = 1'b1;
            rd_adv = 1'b1;
          end
        end
        reb_pkg::REB_RD_INS: begin
          nxt_out = IDLE2;
          nxt_go = 1'b1;
          nxt_state = reb_pkg::REB_RD_PASS;
        end
        default: begin
          nxt_state = reb_pkg::REB_RD_PASS;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_state_ff <= reb_pkg::REB_RD_PASS;
    end else begin
      rd_state_ff <= nxt_state;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_bin_ff <= '0;
      rd_gray_ff <= '0;
    end else if (rd_adv) begin
      rd_bin_ff <= rd_bin_ff + 1'b1;
      rd_gray_ff <= b2g(rd_bin_ff + 1'b1);
    end
  end

  assign rd_if.src_gray = rd_gray_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_ff <= '0;
      valid_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
      valid_ff <= nxt_go;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_in_frame_ff <= 1'b0;
      prev_comma_ff <= 1'b0;
      last_i2_ff <= 1'b0;
    end else if (nxt_go) begin
      if (nxt_out == SOP) begin
        rd_in_frame_ff <= 1'b1;
      end else if (nxt_out == EOP) begin
        rd_in_frame_ff <= 1'b0;
      end
      prev_comma_ff <= (nxt_out == COMMA);
      last_i2_ff <= prev_comma_ff && (nxt_out == IDLE2);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      udf_ff <= 1'b0;
    end else begin
      udf_ff <= rd_tick && rd_run_ff && (rd_occ <= UDF_L);
    end
  end

  assign rx_data = out_ff.d;
  assign rx_is_k = out_ff.k;
  assign rx_valid = valid_ff;
  assign ovf_err = ovf_ff;
  assign udf_err = udf_ff;

  // ---------------- checks ----------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  drop_holds_ptr_a: assert property (
    drop |=> $stable(wr_bin_ff) && !hold_vld_ff
  ) else $error("dropped idle pair was still written");

  drop_above_band_a: assert property (
    drop |-> (wr_occ > HI_L) && !wr_in_frame_ff
  ) else $error("idle dropped while not above the band");

  ins_in_gap_a: assert property (
    (rd_state_ff == reb_pkg::REB_RD_INS) |-> !rd_in_frame_ff
  ) else $error("idle inserted inside a frame");

  ins_below_band_a: assert property (
    $rose(rd_state_ff == reb_pkg::REB_RD_INS) |-> $past(rd_occ) < LO_L
  ) else $error("idle inserted while not below the band");

  ins_pair_order_a: assert property (
    (rd_tick && rd_state_ff == reb_pkg::REB_RD_INS)
      |=> valid_ff && (out_ff == IDLE2) && $past(out_ff) == COMMA
  ) else $error("inserted idle broke comma then data order");

  ovf_flag_a: assert property (
    (wr_edge && wr_occ >= OVF_L) |=> ovf_err ##1 !ovf_err
  ) else $error("overflow not flagged for exactly one cycle");

  udf_flag_a: assert property (
    (rd_tick && rd_run_ff && rd_occ <= UDF_L) |=> udf_err
  ) else $error("underflow mark reached without error");

  gray_step_a: assert property (
    (wr_gray_ff != $past(wr_gray_ff))
      |-> $onehot(wr_gray_ff ^ $past(wr_gray_ff))
  ) else $error("write pointer gray code moved more than one bit");

endmodule : reb_elastic_top
`default_nettype wire

// >>> testbench/reb_link_model.sv
`timescale 1ns/10ps
`default_nettype none
module reb_link_model (
  input wire logic sys_clk,
  output logic link_clk,
  output logic [7:0] link_data,
  output logic link_is_k
);
  // half link period in sys_clk cycles; 8 gives the nominal 160 ns
  int half = 8;

  initial begin
    link_clk = 1'b0;
    link_data = 8'h00;
    link_is_k = 1'b0;
  end

  // clock stands still between calls; held lines then flip so nothing
  // stale can be mistaken for a character
  task automatic send(input logic k, input logic [7:0] d);
    @(negedge sys_clk);
    link_data = d;
    link_is_k = k;
    repeat (half - 1) @(negedge sys_clk);
    link_clk = 1'b1;
    repeat (half) @(negedge sys_clk);
    link_clk = 1'b0;
    link_data = ~d;
    link_is_k = ~k;
  endtask : send
endmodule : reb_link_model
`default_nettype wire

// >>> testbench/reb_elastic_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "reb_cfg.svh"
module reb_elastic_top_tb_top;
  logic sys_clk;
  logic rst = 1'b1;
  logic link_clk;
  logic [7:0] link_data;
  logic link_is_k;
  logic [7:0] rx_data;
  logic rx_is_k;
  logic rx_valid;
  logic ovf_err;
  logic udf_err;
  int n_errors = 0;
  int compares = 0;
  int n_ovf = 0;
  int n_udf = 0;
  logic in_frame = 1'b0;
  logic last_comma = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] got_q[$];

  reb_elastic_top dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .link_clk(link_clk),
    .link_data(link_data),
    .link_is_k(link_is_k),
    .rx_data(rx_data),
    .rx_is_k(rx_is_k),
    .rx_valid(rx_valid),
    .ovf_err(ovf_err),
    .udf_err(udf_err)
  );

  reb_link_model link (
    .sys_clk(sys_clk),
    .link_clk(link_clk),
    .link_data(link_data),
    .link_is_k(link_is_k)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // sampled on the falling edge so pulses are seen settled and once
  always @(negedge sys_clk) begin
    if (ovf_err === 1'b1) n_ovf++;
    if (udf_err === 1'b1) n_udf++;
    if (rx_valid === 1'b1) begin
      if (last_comma) chk({rx_is_k, rx_data}, {1'b0, `REB_D_IDLE2});
      last_comma = rx_is_k && rx_data == `REB_K_COMMA;
      if (rx_is_k && rx_data == `REB_K_SOP) in_frame = 1'b1;
      else if (rx_is_k && rx_data == `REB_K_EOP) in_frame = 1'b0;
      else if (in_frame && !rx_is_k) got_q.push_back(rx_data);
    end
  end

  task automatic gap(input int n);
    repeat (n) begin
      link.send(1'b1, `REB_K_COMMA);
      link.send(1'b0, `REB_D_IDLE2);
    end
  endtask : gap

  // even payload keeps the end marker odd, so idles restart even
  task automatic frame(input int len, input logic [7:0] base);
    link.send(1'b1, `REB_K_SOP);
    for (int i = 0; i < len; i++) begin
      link.send(1'b0, base + 8'(i));
      exp_q.push_back(base + 8'(i));
    end
    link.send(1'b1, `REB_K_EOP);
  endtask : frame

  task automatic payload;
    link.half = 8;
    gap(24);
    chk(9'(got_q.size()), 9'(exp_q.size()));
    while (exp_q.size() > 0 && got_q.size() > 0)
      chk({1'b0, got_q.pop_front()}, {1'b0, exp_q.pop_front()});
    exp_q.delete();
    got_q.delete();
  endtask : payload

  task automatic t_reset;
    chk({6'h00, rx_valid, ovf_err, udf_err}, 9'h000);
  endtask : t_reset

  task automatic t_pass;
    gap(24);
    frame(20, 8'h10);
    gap(4);
    frame(30, 8'h40);
    payload();
    chk(9'(n_ovf + n_udf), 9'h000);
  endtask : t_pass

  // link faster than reads: only idle pairs may go, the payload stays
  task automatic t_drop;
    link.half = 5;
    gap(60);
    frame(10, 8'h80);
    gap(10);
    payload();
    chk(9'(n_ovf), 9'h000);
  endtask : t_drop

  // link slower than reads: idle pairs are added instead of running dry
  task automatic t_slow;
    link.half = 12;
    gap(40);
    frame(10, 8'hA0);
    gap(10);
    payload();
    chk(9'(n_udf), 9'h000);
  endtask : t_slow

  // 100 Mb/s style: every byte sent ten times, a gap of 40 bytes before
  // the frame and 80 after; the faster link forces the gap to give up idle pairs
  task automatic t_rep;
    link.half = 6;
    gap(20);
    link.send(1'b1, `REB_K_SOP);
    for (int i = 0; i < 60; i++) begin
      link.send(1'b0, 8'h60 + 8'(i / 10));
      exp_q.push_back(8'h60 + 8'(i / 10));
    end
    link.send(1'b1, `REB_K_EOP);
    gap(40);
    payload();
    chk(9'(n_ovf), 9'h000);
  endtask : t_rep

  // stall in mid-frame, where no idle may be added; the frame must be
  // longer than the fill so the reader is inside it when the link stops,
  // otherwise it pads the gap with idles and never drains
  task automatic t_under;
    link.send(1'b1, `REB_K_SOP);
    for (int i = 0; i < 40; i++) begin
      link.send(1'b0, 8'hC0 + 8'(i));
      exp_q.push_back(8'hC0 + 8'(i));
    end
    repeat (800) @(negedge sys_clk);
    chk({8'h00, n_udf > 0}, 9'h001);
    link.send(1'b1, `REB_K_EOP);
    payload();
  endtask : t_under

  task automatic t_over;
    link.half = 5;
    link.send(1'b1, `REB_K_SOP);
    for (int i = 0; i < 90; i++) link.send(1'b0, 8'(i));
    link.send(1'b1, `REB_K_EOP);
    chk({8'h00, n_ovf > 0}, 9'h001);
    gap(10);
  endtask : t_over

  // reset in mid-run with data still queued; the buffer must restart clean
  task automatic t_again;
    rst = 1'b1;
    repeat (8) @(negedge sys_clk);
    t_reset();
    in_frame = 1'b0;
    last_comma = 1'b0;
    exp_q.delete();
    got_q.delete();
    rst = 1'b0;
    @(negedge sys_clk);
    t_reset();
    link.half = 8;
    gap(24);
    frame(8, 8'h30);
    payload();
  endtask : t_again

  task automatic summarize;
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    summarize();
  end

  initial begin
    repeat (8) @(negedge sys_clk);
    t_reset();
    rst = 1'b0;
    @(negedge sys_clk);
    t_reset();
    t_pass();
    t_drop();
    t_slow();
    t_rep();
    t_under();
    t_over();
    t_again();
    summarize();
  end
endmodule : reb_elastic_top_tb_top
`default_nettype wire
